// [syscmd_regs.svh]
// Purpose: Named constants for the system command handler.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Contract
`ifndef SYSCMD_REGS_SVH
`define SYSCMD_REGS_SVH
`define LEN_BYTES_PER_VALUE 32'h0000_0008
`define LEN_NONE            32'h0000_0000
`define FIRST_SAMPLE_INDEX  16'h0001
`define SUBSYS_RESET        3'h0
`define TONE_VALUE_RESET    32'h0000_0000
`define TONE_MODE_BIT       0
`define SUBSYS_FIELD_MSB    2
`define FN_FIELD_MSB        1
`endif

// [syscmd_pkg.sv]
// Purpose: Types shared by the system command handler, its checker and bench.
// Assumes: Commands arrive already parsed, one per valid cycle.
// Notes:   Encodings are internal to the instrument.
package syscmd_pkg;
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_HALT      = 4'h1,
    CMD_STOP_HC   = 4'h2,
    CMD_FLUSH     = 4'h3,
    CMD_Q_BLOCK_LAST_INDEX_QUERY    = 4'h4,
    CMD_Q_BLOCK_ARM_INTERVAL_QUERY    = 4'h5,
    CMD_Q_PER_BLOCK_CARRIER_QUERY    = 4'h6,
    CMD_TONE_MODE = 4'h7,
    CMD_TONE_VAL  = 4'h8,
    CMD_SET_FN    = 4'h9,
    CMD_SELECT    = 4'hA,
    CMD_COMMON    = 4'hB
  } cmd_code_t;

  typedef enum logic [1:0] {
    FN_OTHER      = 2'h0,
    FN_PHASE_DEV  = 2'h1,
    FN_TIME_DEV   = 2'h2
  } meas_fn_t;

  typedef enum logic [1:0] {
    LIST_BLOCK_LAST_INDEX_QUERY     = 2'h0,
    LIST_BLOCK_ARM_INTERVAL_QUERY     = 2'h1,
    LIST_PER_BLOCK_CARRIER_QUERY     = 2'h2
  } list_kind_t;

  // Gray along idle -> length -> values
  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_LEN        = 2'b01,
    ST_VAL        = 2'b11
  } stream_state_t;

  typedef struct packed {
    cmd_code_t   code;
    logic        is_system;
    logic        is_common;
    logic        long_form;
    logic [31:0] arg;
  } cmd_t;

  typedef struct packed {
    logic        is_len;
    logic [31:0] value;
  } out_word_t;
endpackage

// [syscmd_skid_buf.sv]
// Purpose: Two-entry buffer between list streamer and output port.
// Assumes: Same clock on both sides.
// Notes:   Outputs come from flops; ready drops once the spare entry fills.
`timescale 1ns/100ps
module syscmd_skid_buf #(
  parameter int WIDTH = 33
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic             tail_valid;
  logic [WIDTH-1:0] tail;
  logic             push;
  logic             pop;

  assign in_ready_o = ~tail_valid;
  assign push       = in_valid_i & ~tail_valid;
  assign pop        = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      tail_valid  <= 1'b0;
      tail        <= '0;
    end
    else if (flush_i)
    begin
      out_valid_o <= 1'b0;
      tail_valid  <= 1'b0;
    end
    else if (pop)
    begin
      if (tail_valid)
      begin
        out_data_o <= tail;
        tail_valid <= 1'b0;
      end
      else if (push)
        out_data_o <= in_data_i;
      else
        out_valid_o <= 1'b0;
    end
    else if (push)
    begin
      if (!out_valid_o)
      begin
        out_data_o  <= in_data_i;
        out_valid_o <= 1'b1;
      end
      else
      begin
        tail       <= in_data_i;
        tail_valid <= 1'b1;
      end
    end
  end
endmodule

// [syscmd_handler.sv]
// Purpose: Executes system level commands and streams per-block list answers.
// Assumes: Parsed commands, bus clears and acquisition events share MCLK_I.
// Notes:   List words leave through a two-entry buffer; a stall loses nothing.
`timescale 1ns/100ps
`include "syscmd_regs.svh"
module syscmd_handler #(
  parameter int MAX_BLOCKS = 16,
  parameter int IDX_W      = 16
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  CMD_VALID_I,
  input  wire syscmd_pkg::cmd_t      CMD_I,
  input  wire logic                  LISTEN_I,
  input  wire logic                  FLOAT_FMT_I,
  input  wire logic                  DEV_CLEAR_I,
  input  wire logic                  HC_START_I,
  input  wire logic                  ACQ_START_I,
  input  wire logic                  SAMPLE_I,
  input  wire logic [31:0]           SAMPLE_VALUE_I,
  input  wire logic                  BLOCK_END_I,
  input  wire logic [31:0]           ARM_INTERVAL_I,
  input  wire logic                  ARM_TIMED_I,
  input  wire logic                  OUT_READY_I,
  output logic                       OUT_VALID_O,
  output syscmd_pkg::out_word_t      OUT_WORD_O,
  output logic [2:0]                 ACTIVE_SUBSYS_O,
  output logic                       ACQ_ACTIVE_O,
  output logic                       MEAS_HALT_O,
  output logic                       HC_ACTIVE_O,
  output logic                       HC_STOP_O,
  output logic                       BUF_FLUSH_O,
  output logic                       DEFER_DISCARD_O,
  output logic                       STATIC_FAIL_CLR_O,
  output logic                       STATUS_RESET_O,
  output logic                       CMD_DONE_O,
  output logic                       CMD_ERR_O
);
  localparam int BW = $clog2(MAX_BLOCKS);

  logic [IDX_W-1:0] blk_end [MAX_BLOCKS];
  logic [31:0]      blk_arm [MAX_BLOCKS];
  logic [31:0]      blk_sum [MAX_BLOCKS];

  logic                      take;
  logic                      bad_form;
  logic                      exec;
  logic                      sys_exec;
  logic                      flush_all;
  logic                      query;
  logic                      busy_reject;
  logic                      halt_cmd;
  logic                      stop_hc_cmd;
  logic [BW:0]               nblk;
  logic [IDX_W-1:0]          meas_idx;
  logic [31:0]               run_sum;
  logic                      tone_auto;
  logic [31:0]               tone_value;
  syscmd_pkg::meas_fn_t      meas_fn;
  syscmd_pkg::stream_state_t st;
  syscmd_pkg::list_kind_t    kind;
  logic [BW:0]               q_blocks;
  logic [BW:0]               idx;
  logic                      half;
  logic                      push_valid;
  logic                      push_ready;
  logic                      pushed;
  syscmd_pkg::out_word_t     push_word;
  logic [BW-1:0]             sel;
  logic [IDX_W-1:0]          prev_end;

  // Length field of a list: value count in ASCII, bytes in floating point
  function automatic logic [31:0] len_field(input logic [31:0] nvals, input logic float_fmt);
    len_field = float_fmt ? 32'(nvals * `LEN_BYTES_PER_VALUE) : nvals;
  endfunction

  // Mean of a block's samples; an empty block reads as zero
  function automatic logic [31:0] block_mean(input logic [31:0] sum, input logic [IDX_W-1:0] cnt);
    block_mean = (cnt == '0) ? 32'h0000_0000 : sum / 32'(cnt);
  endfunction

  // Carrier lists exist only for the two deviation functions
  function automatic logic is_deviation(input syscmd_pkg::meas_fn_t fn);
    is_deviation = (fn == syscmd_pkg::FN_PHASE_DEV) || (fn == syscmd_pkg::FN_TIME_DEV);
  endfunction

  // One of the three list queries
  function automatic logic is_list_query(input syscmd_pkg::cmd_code_t code);
    is_list_query = (code == syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY) || (code == syscmd_pkg::CMD_Q_BLOCK_ARM_INTERVAL_QUERY) ||
                    (code == syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY);
  endfunction

  // Bus clears act even during hardcopy; other commands need listen addressing
  assign take      = CMD_VALID_I & (~HC_ACTIVE_O | LISTEN_I);
  assign bad_form  = CMD_I.is_common & CMD_I.long_form;
  assign exec      = take & ~bad_form;
  assign sys_exec  = exec & CMD_I.is_system;
  assign flush_all = DEV_CLEAR_I | (sys_exec & (CMD_I.code == syscmd_pkg::CMD_FLUSH));
  assign query     = sys_exec & is_list_query(CMD_I.code);
  assign halt_cmd    = sys_exec & (CMD_I.code == syscmd_pkg::CMD_HALT);
  assign stop_hc_cmd = sys_exec & (CMD_I.code == syscmd_pkg::CMD_STOP_HC);
  // A second query while a list is still going out is refused, not queued
  assign busy_reject = query & (st != syscmd_pkg::ST_IDLE) & ~flush_all;

  // Subsystem selection changes only on an explicit subsystem select
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      ACTIVE_SUBSYS_O <= `SUBSYS_RESET;
    else if (exec && !CMD_I.is_system && CMD_I.code == syscmd_pkg::CMD_SELECT)
      ACTIVE_SUBSYS_O <= CMD_I.arg[`SUBSYS_FIELD_MSB:0];
  end

  // Command outcome and clear pulses
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      CMD_DONE_O        <= 1'b0;
      CMD_ERR_O         <= 1'b0;
      BUF_FLUSH_O       <= 1'b0;
      DEFER_DISCARD_O   <= 1'b0;
      STATIC_FAIL_CLR_O <= 1'b0;
      STATUS_RESET_O    <= 1'b0;
      MEAS_HALT_O       <= 1'b0;
    end
    else
    begin
      CMD_DONE_O        <= exec & ~busy_reject;
      CMD_ERR_O         <= (take & bad_form) | busy_reject;
      BUF_FLUSH_O       <= flush_all;
      DEFER_DISCARD_O   <= flush_all;
      STATIC_FAIL_CLR_O <= DEV_CLEAR_I;
      STATUS_RESET_O    <= DEV_CLEAR_I;
      // A halt pulse only means something while an acquisition runs
      MEAS_HALT_O       <= ACQ_ACTIVE_O & (flush_all | halt_cmd);
    end
  end

  // Acquisition bookkeeping; a halt ends it but keeps what was gathered
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ACQ_ACTIVE_O <= 1'b0;
      nblk         <= '0;
      meas_idx     <= '0;
      run_sum      <= '0;
    end
    else if (flush_all || halt_cmd)
      ACQ_ACTIVE_O <= 1'b0;
    else if (ACQ_START_I)
    begin
      ACQ_ACTIVE_O <= 1'b1;
      nblk         <= '0;
      meas_idx     <= '0;
      run_sum      <= '0;
    end
    else if (ACQ_ACTIVE_O)
    begin
      if (SAMPLE_I)
      begin
        meas_idx <= meas_idx + 1'b1;
        run_sum  <= run_sum + SAMPLE_VALUE_I;
      end
      // Blocks past the end of the table are dropped; the count saturates
      if (BLOCK_END_I && nblk < (BW+1)'(MAX_BLOCKS))
      begin
        nblk    <= nblk + 1'b1;
        run_sum <= '0;
      end
    end
  end

  // Block table; the sample landing with a block end belongs to that block
  always_ff @(posedge MCLK_I)
  begin
    if (ACQ_ACTIVE_O && !flush_all && BLOCK_END_I && nblk < (BW+1)'(MAX_BLOCKS))
    begin
      blk_end[nblk[BW-1:0]] <= SAMPLE_I ? meas_idx + 1'b1 : meas_idx;
      blk_arm[nblk[BW-1:0]] <= ARM_INTERVAL_I;
      blk_sum[nblk[BW-1:0]] <= SAMPLE_I ? run_sum + SAMPLE_VALUE_I : run_sum;
    end
  end

  // Hardcopy: talk-only while printing or plotting
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      HC_ACTIVE_O <= 1'b0;
      HC_STOP_O   <= 1'b0;
    end
    else
    begin
      HC_STOP_O <= 1'b0;
      // A stop with no hardcopy running completes but pulses nothing
      if (stop_hc_cmd)
      begin
        HC_ACTIVE_O <= 1'b0;
        HC_STOP_O   <= HC_ACTIVE_O;
      end
      else if (HC_START_I)
        HC_ACTIVE_O <= 1'b1;
    end
  end

  // Measurement function and reference tone settings
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tone_auto  <= 1'b0;
      tone_value <= `TONE_VALUE_RESET;
      meas_fn    <= syscmd_pkg::FN_OTHER;
    end
    else if (exec)
    begin
      case (CMD_I.code)
        syscmd_pkg::CMD_TONE_MODE: tone_auto  <= CMD_I.arg[`TONE_MODE_BIT];
        syscmd_pkg::CMD_TONE_VAL:  tone_value <= CMD_I.arg;
        syscmd_pkg::CMD_SET_FN:    meas_fn    <= syscmd_pkg::meas_fn_t'(CMD_I.arg[`FN_FIELD_MSB:0]);
        default:                   tone_auto  <= tone_auto;
      endcase
    end
  end

  // Word selection for the list streamer
  assign sel      = idx[BW-1:0];
  assign prev_end = (idx == '0) ? '0 : blk_end[BW'(idx - 1'b1)];

  always_comb
  begin
    push_valid = (st != syscmd_pkg::ST_IDLE);
    push_word  = '0;
    if (st == syscmd_pkg::ST_LEN)
    begin
      push_word.is_len = 1'b1;
      push_word.value  = len_field((kind == syscmd_pkg::LIST_BLOCK_ARM_INTERVAL_QUERY) ? 32'(q_blocks) << 1 : 32'(q_blocks),
                                   FLOAT_FMT_I);
    end
    else
    begin
      case (kind)
        syscmd_pkg::LIST_BLOCK_LAST_INDEX_QUERY:
          push_word.value = 32'(blk_end[sel]);
        syscmd_pkg::LIST_BLOCK_ARM_INTERVAL_QUERY:
          push_word.value = half ? blk_arm[sel] : 32'(prev_end + `FIRST_SAMPLE_INDEX);
        default:
          push_word.value = tone_auto ? block_mean(blk_sum[sel], blk_end[sel] - prev_end)
                                      : tone_value;
      endcase
    end
  end

  assign pushed = push_valid & push_ready;

  // List streamer: length field then values, block by block
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      st       <= syscmd_pkg::ST_IDLE;
      kind     <= syscmd_pkg::LIST_BLOCK_LAST_INDEX_QUERY;
      q_blocks <= '0;
      idx      <= '0;
      half     <= 1'b0;
    end
    else if (flush_all)
      st <= syscmd_pkg::ST_IDLE;
    else
    begin
      case (st)
        syscmd_pkg::ST_IDLE:
        begin
          if (query)
          begin
            st   <= syscmd_pkg::ST_LEN;
            idx  <= '0;
            half <= 1'b0;
            case (CMD_I.code)
              syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY:
              begin
                kind     <= syscmd_pkg::LIST_BLOCK_LAST_INDEX_QUERY;
                q_blocks <= nblk;
              end
              syscmd_pkg::CMD_Q_BLOCK_ARM_INTERVAL_QUERY:
              begin
                kind     <= syscmd_pkg::LIST_BLOCK_ARM_INTERVAL_QUERY;
                q_blocks <= ARM_TIMED_I ? nblk : '0;
              end
              default:
              begin
                kind     <= syscmd_pkg::LIST_PER_BLOCK_CARRIER_QUERY;
                q_blocks <= is_deviation(meas_fn)
                            ? nblk : '0;
              end
            endcase
          end
        end
        syscmd_pkg::ST_LEN:
        begin
          // An empty list ends right after its length word
          if (pushed)
            st <= (q_blocks == '0) ? syscmd_pkg::ST_IDLE : syscmd_pkg::ST_VAL;
        end
        syscmd_pkg::ST_VAL:
        begin
          if (pushed)
          begin
            // Arm interval lists send index then interval before moving on
            if (kind == syscmd_pkg::LIST_BLOCK_ARM_INTERVAL_QUERY && !half)
              half <= 1'b1;
            else
            begin
              half <= 1'b0;
              idx  <= idx + 1'b1;
              if (idx + 1'b1 == q_blocks)
                st <= syscmd_pkg::ST_IDLE;
            end
          end
        end
        default:
          st <= syscmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Output buffer is emptied along with the streamer on any flush
  syscmd_skid_buf #(
    .WIDTH       ($bits(syscmd_pkg::out_word_t))
  ) u_out_buf (
    .clk_i       (MCLK_I),
    .rst_n_i     (RSTN_I),
    .flush_i     (flush_all),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_word),
    .out_valid_o (OUT_VALID_O),
    .out_ready_i (OUT_READY_I),
    .out_data_o  (OUT_WORD_O)
  );
endmodule

// [syscmd_handler_assertions.sv]
// Purpose: Port-level checks on the system command handler.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Flush and bus clear may drop a standing word, so hold checks skip them.
`timescale 1ns/100ps
module syscmd_handler_checker (
  input wire logic                  MCLK_I,
  input wire logic                  RSTN_I,
  input wire logic                  CMD_VALID_I,
  input wire syscmd_pkg::cmd_t      CMD_I,
  input wire logic                  LISTEN_I,
  input wire logic                  DEV_CLEAR_I,
  input wire logic                  OUT_READY_I,
  input wire logic                  OUT_VALID_O,
  input wire syscmd_pkg::out_word_t OUT_WORD_O,
  input wire logic [2:0]            ACTIVE_SUBSYS_O,
  input wire logic                  ACQ_ACTIVE_O,
  input wire logic                  MEAS_HALT_O,
  input wire logic                  HC_ACTIVE_O,
  input wire logic                  HC_STOP_O,
  input wire logic                  BUF_FLUSH_O,
  input wire logic                  DEFER_DISCARD_O,
  input wire logic                  STATIC_FAIL_CLR_O,
  input wire logic                  STATUS_RESET_O,
  input wire logic                  CMD_DONE_O,
  input wire logic                  CMD_ERR_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  logic take;
  assign take = CMD_VALID_I && (!HC_ACTIVE_O || LISTEN_I) && !DEV_CLEAR_I;
  sequence s_halt_out;
    MEAS_HALT_O ##[0:1] !ACQ_ACTIVE_O;
  endsequence
  sequence s_hc_out;
    HC_STOP_O ##[0:1] !HC_ACTIVE_O;
  endsequence
  property p_answer;
    take |=> CMD_DONE_O != CMD_ERR_O;
  endproperty
  property p_short_only;
    take && CMD_I.is_common && CMD_I.long_form |=> CMD_ERR_O && $stable(ACTIVE_SUBSYS_O);
  endproperty
  property p_keep_subsys;
    take && CMD_I.is_system |=> $stable(ACTIVE_SUBSYS_O);
  endproperty
  property p_deaf_hc;
    CMD_VALID_I && HC_ACTIVE_O && !LISTEN_I |=> !CMD_DONE_O && !CMD_ERR_O;
  endproperty
  property p_halt;
    take && CMD_I.code == syscmd_pkg::CMD_HALT && ACQ_ACTIVE_O |=> s_halt_out;
  endproperty
  property p_stop_hc;
    take && CMD_I.code == syscmd_pkg::CMD_STOP_HC && HC_ACTIVE_O |=> s_hc_out;
  endproperty
  property p_bus_clear;
    DEV_CLEAR_I |=> BUF_FLUSH_O && DEFER_DISCARD_O && STATIC_FAIL_CLR_O && STATUS_RESET_O;
  endproperty
  property p_flush_cmd;
    take && CMD_I.code == syscmd_pkg::CMD_FLUSH
      |=> BUF_FLUSH_O && DEFER_DISCARD_O && !STATIC_FAIL_CLR_O && !STATUS_RESET_O;
  endproperty
  property p_hold;
    OUT_VALID_O && !OUT_READY_I && !DEV_CLEAR_I && !(take && CMD_I.code == syscmd_pkg::CMD_FLUSH)
      |=> OUT_VALID_O && $stable(OUT_WORD_O);
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  a_short_only: assert property (p_short_only) else $error("long common accepted");
  a_keep_subsys: assert property (p_keep_subsys) else $error("subsystem moved");
  a_deaf_hc: assert property (p_deaf_hc) else $error("answered in hardcopy");
  a_halt: assert property (p_halt) else $error("halt missing");
  a_stop_hc: assert property (p_stop_hc) else $error("hardcopy not stopped");
  a_bus_clear: assert property (p_bus_clear) else $error("bus clear incomplete");
  a_flush_cmd: assert property (p_flush_cmd) else $error("flush wrong");
  a_hold: assert property (p_hold) else $error("word lost");
endmodule
bind syscmd_handler syscmd_handler_checker u_syscmd_handler_checker (
  .MCLK_I, .RSTN_I, .CMD_VALID_I, .CMD_I, .LISTEN_I, .DEV_CLEAR_I, .OUT_READY_I, .OUT_VALID_O,
  .OUT_WORD_O, .ACTIVE_SUBSYS_O, .ACQ_ACTIVE_O, .MEAS_HALT_O, .HC_ACTIVE_O, .HC_STOP_O,
  .BUF_FLUSH_O, .DEFER_DISCARD_O, .STATIC_FAIL_CLR_O, .STATUS_RESET_O, .CMD_DONE_O, .CMD_ERR_O
);

// [syscmd_host_sink.sv]
// Purpose: Controller side that reads list words from the handler.
// Assumes: A word passes on a rising edge where valid and ready meet.
// Notes:   Hold blocks all reads; slow takes one edge in four.
`timescale 1ns/100ps
module syscmd_host_sink (
  input  wire logic                  clk_i,
  input  wire logic                  hold_i,
  input  wire logic                  slow_i,
  input  wire logic                  valid_i,
  input  wire syscmd_pkg::out_word_t word_i,
  output logic                       ready_o
);
  syscmd_pkg::out_word_t got[$];
  logic [1:0]            tick;
  initial
  begin
    tick = 2'h0;
    ready_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
      got.push_back(word_i);
    tick = tick + 2'h1;
    ready_o <= #1 !hold_i && (!slow_i || tick == 2'h0);
  end
endmodule

// [syscmd_handler_tb.sv]
// Purpose: Self-checking bench for the system command handler.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Response vector is done, err, halt, hc stop, flush, discard, fail clr, status rst.
`timescale 1ns/100ps
module syscmd_handler_tb;
  logic MCLK_I, RSTN_I, CMD_VALID_I, LISTEN_I, FLOAT_FMT_I, DEV_CLEAR_I, HC_START_I, ACQ_START_I;
  logic SAMPLE_I, BLOCK_END_I, ARM_TIMED_I, OUT_READY_I, OUT_VALID_O, ACQ_ACTIVE_O, MEAS_HALT_O;
  logic HC_ACTIVE_O, HC_STOP_O, BUF_FLUSH_O, DEFER_DISCARD_O, STATIC_FAIL_CLR_O, STATUS_RESET_O;
  logic CMD_DONE_O, CMD_ERR_O, hold, slow;
  logic [31:0]           SAMPLE_VALUE_I, ARM_INTERVAL_I;
  logic [2:0]            ACTIVE_SUBSYS_O;
  logic [7:0]            rsp;
  syscmd_pkg::cmd_t      CMD_I;
  syscmd_pkg::out_word_t OUT_WORD_O;
  syscmd_pkg::out_word_t exp[$];
  int                    n_fail, n_tests;
  syscmd_handler u_syscmd_handler (
    .MCLK_I, .RSTN_I, .CMD_VALID_I, .CMD_I, .LISTEN_I, .FLOAT_FMT_I, .DEV_CLEAR_I, .HC_START_I,
    .ACQ_START_I, .SAMPLE_I, .SAMPLE_VALUE_I, .BLOCK_END_I, .ARM_INTERVAL_I, .ARM_TIMED_I,
    .OUT_READY_I, .OUT_VALID_O, .OUT_WORD_O, .ACTIVE_SUBSYS_O, .ACQ_ACTIVE_O, .MEAS_HALT_O,
    .HC_ACTIVE_O, .HC_STOP_O, .BUF_FLUSH_O, .DEFER_DISCARD_O, .STATIC_FAIL_CLR_O,
    .STATUS_RESET_O, .CMD_DONE_O, .CMD_ERR_O
  );
  syscmd_host_sink u_syscmd_host_sink (.clk_i(MCLK_I), .hold_i(hold), .slow_i(slow),
    .valid_i(OUT_VALID_O), .word_i(OUT_WORD_O), .ready_o(OUT_READY_I));
  always #25 MCLK_I = !MCLK_I;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_word(input syscmd_pkg::out_word_t got, input syscmd_pkg::out_word_t want);
    n_tests++;
    if (got !== want)
    begin
      n_fail++;
      $display("unexpected word at %0t: %h not %h", $time, got, want);
    end
  endtask
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want)
    begin
      n_fail++;
      $display("unexpected flags at %0t: %h not %h", $time, got, want);
    end
  endtask
  task automatic step();
    @(posedge MCLK_I);
    #1;
  endtask
  task automatic cmd(input syscmd_pkg::cmd_code_t c, input logic [31:0] a, input logic lng = 1'b0,
                     input logic dcl = 1'b0);
    CMD_VALID_I = !dcl;
    DEV_CLEAR_I = dcl;
    CMD_I.code = c;
    CMD_I.is_system = c <= syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY || c == syscmd_pkg::CMD_COMMON;
    CMD_I.is_common = c == syscmd_pkg::CMD_COMMON;
    CMD_I.long_form = lng;
    CMD_I.arg = a;
    step();
    // Answer pulses stand only in the cycle right after the take
    rsp = {CMD_DONE_O, CMD_ERR_O, MEAS_HALT_O, HC_STOP_O, BUF_FLUSH_O, DEFER_DISCARD_O,
           STATIC_FAIL_CLR_O, STATUS_RESET_O};
    CMD_VALID_I = 1'b0;
    DEV_CLEAR_I = 1'b0;
    step();
  endtask
  task automatic len(input int n);
    exp.push_back({1'b1, FLOAT_FMT_I ? 32'(8 * n) : 32'(n)});
  endtask
  task automatic val(input logic [31:0] v);
    exp.push_back({1'b0, v});
  endtask
  // Bounded wait, then a few idle edges so surplus words show up too
  task automatic list(input syscmd_pkg::cmd_code_t q);
    cmd(q, 32'h0);
    chk_bits(rsp, 8'h80);
    for (int k = 0; k < 300 && u_syscmd_host_sink.got.size() < exp.size(); k++)
      step();
    repeat (4) step();
    chk_bits(8'(u_syscmd_host_sink.got.size()), 8'(exp.size()));
    foreach (exp[i])
      chk_word(i < u_syscmd_host_sink.got.size() ? u_syscmd_host_sink.got[i] : '1, exp[i]);
    exp.delete();
    u_syscmd_host_sink.got.delete();
  endtask
  task automatic t_empty();
    syscmd_pkg::cmd_code_t qs[3] = '{syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY, syscmd_pkg::CMD_Q_BLOCK_ARM_INTERVAL_QUERY, syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY};
    foreach (qs[i])
    begin
      len(0);
      list(qs[i]);
    end
    $display("test empty lists ended");
  endtask
  task automatic t_subsys();
    cmd(syscmd_pkg::CMD_SELECT, 32'h5);
    cmd(syscmd_pkg::CMD_COMMON, 32'h0, 1'b1);
    chk_bits(rsp, 8'h40);
    cmd(syscmd_pkg::CMD_COMMON, 32'h0);
    chk_bits(rsp, 8'h80);
    cmd(syscmd_pkg::CMD_FLUSH, 32'h0);
    chk_bits(rsp, 8'h8C);
    chk_bits(8'(ACTIVE_SUBSYS_O), 8'h05);
    $display("test subsystem ended");
  endtask
  task automatic t_block_last_index_query();
    ACQ_START_I = 1'b1;
    step();
    ACQ_START_I = 1'b0;
    for (int i = 1; i <= 6; i++)
    begin
      SAMPLE_I = 1'b1;
      SAMPLE_VALUE_I = 32'(2 * i);
      BLOCK_END_I = i % 2 == 0;
      ARM_INTERVAL_I = 32'h100 + 32'(i);
      step();
    end
    SAMPLE_I = 1'b0;
    BLOCK_END_I = 1'b0;
    chk_bits(8'(ACQ_ACTIVE_O), 8'h01);
    cmd(syscmd_pkg::CMD_HALT, 32'h0);
    chk_bits(rsp, 8'hA0);
    chk_bits(8'(ACQ_ACTIVE_O), 8'h00);
    slow = 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      FLOAT_FMT_I = f[0];
      len(3);
      for (int b = 1; b <= 3; b++)
        val(32'(2 * b));
      list(syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY);
    end
    FLOAT_FMT_I = 1'b0;
    slow = 1'b0;
    $display("test block ends ended");
  endtask
  task automatic t_block_arm_interval_query();
    ARM_TIMED_I = 1'b1;
    len(6);
    for (int b = 0; b < 3; b++)
    begin
      val(32'(2 * b + 1));
      val(32'h100 + 32'(2 * b + 2));
    end
    list(syscmd_pkg::CMD_Q_BLOCK_ARM_INTERVAL_QUERY);
    ARM_TIMED_I = 1'b0;
    len(0);
    list(syscmd_pkg::CMD_Q_BLOCK_ARM_INTERVAL_QUERY);
    $display("test arm intervals ended");
  endtask
  task automatic t_per_block_carrier_query();
    cmd(syscmd_pkg::CMD_SET_FN, 32'h1);
    cmd(syscmd_pkg::CMD_TONE_MODE, 32'h0);
    cmd(syscmd_pkg::CMD_TONE_VAL, 32'h1234);
    len(3);
    repeat (3) val(32'h1234);
    list(syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY);
    cmd(syscmd_pkg::CMD_TONE_MODE, 32'h1);
    for (int fn = 1; fn <= 2; fn++)
    begin
      cmd(syscmd_pkg::CMD_SET_FN, 32'(fn));
      len(3);
      for (int b = 0; b < 3; b++)
        val(32'(4 * b + 3));
      list(syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY);
    end
    cmd(syscmd_pkg::CMD_SET_FN, 32'h0);
    len(0);
    list(syscmd_pkg::CMD_Q_PER_BLOCK_CARRIER_QUERY);
    $display("test carriers ended");
  endtask
  task automatic t_clear();
    hold = 1'b1;
    cmd(syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY, 32'h0);
    repeat (3) step();
    cmd(syscmd_pkg::CMD_Q_BLOCK_LAST_INDEX_QUERY, 32'h0);
    chk_bits(rsp, 8'h40);
    ACQ_START_I = 1'b1;
    step();
    ACQ_START_I = 1'b0;
    cmd(syscmd_pkg::CMD_FLUSH, 32'h0);
    chk_bits(rsp, 8'hAC);
    chk_bits(8'(ACQ_ACTIVE_O), 8'h00);
    hold = 1'b0;
    repeat (5) step();
    chk_bits(8'(u_syscmd_host_sink.got.size()), 8'h00);
    cmd(syscmd_pkg::CMD_NONE, 32'h0, 1'b0, 1'b1);
    chk_bits(rsp, 8'h0F);
    $display("test clears ended");
  endtask
  task automatic t_hardcopy();
    HC_START_I = 1'b1;
    step();
    HC_START_I = 1'b0;
    cmd(syscmd_pkg::CMD_HALT, 32'h0);
    chk_bits(rsp, 8'h00);
    LISTEN_I = 1'b1;
    cmd(syscmd_pkg::CMD_STOP_HC, 32'h0);
    chk_bits(rsp, 8'h90);
    LISTEN_I = 1'b0;
    step();
    chk_bits(8'(HC_ACTIVE_O), 8'h00);
    $display("test hardcopy ended");
  endtask
  initial
  begin
    {MCLK_I, RSTN_I, CMD_VALID_I, LISTEN_I, FLOAT_FMT_I, DEV_CLEAR_I, HC_START_I} = 7'h00;
    {ACQ_START_I, SAMPLE_I, BLOCK_END_I, ARM_TIMED_I, hold, slow} = 6'h00;
    {SAMPLE_VALUE_I, ARM_INTERVAL_I} = 64'h0;
    CMD_I = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge MCLK_I);
    #1 RSTN_I = 1'b1;
    t_empty();
    t_subsys();
    t_block_last_index_query();
    t_block_arm_interval_query();
    t_per_block_carrier_query();
    t_clear();
    t_hardcopy();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
